// >>> verif/apo_analog_power_override_regs_tb.sv
`timescale 1ns/10ps
// ----------------
// Bench for the override bank
// ----------------
module apo_analog_power_override_regs_tb import apo_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  apo_addr_t regAddr = 8'h00;
  apo_byte_t regWdata = 8'h00;
  apo_byte_t seq = 8'h0F;
  apo_byte_t regRdata;
  logic regHit;
  logic [7:0] pathL, auxL, pathR, auxR;
  int n_mismatch = 0;
  int checks_done = 0;
  // Rows: address, write data, read-back; unmapped ones read 0
  logic [23:0] rows [10] = '{24'h22FF_FF, 24'h24A5_A5, 24'h23FF_FF, 24'h255A_5A, 24'h26FF_FF,
    24'h280A_0A, 24'h27FF_FF, 24'h29C3_C3, 24'h21FF_00, 24'h2AFF_00};
  always #25 clk = ~clk;
  apo_analog_power_override_regs dut_u (.clk, .sys_rst, .regWrite, .regRead, .regAddr,
    .regWdata, .regRdata, .regHit, .seqPathPwrdnLeft(seq), .seqAuxPwrdnLeft(seq),
    .seqPathPwrdnRight(seq), .seqAuxPwrdnRight(seq), .pathPwrdnLeft(pathL),
    .auxPwrdnLeft(auxL), .pathPwrdnRight(pathR), .auxPwrdnRight(auxR));
  task ck(input logic [7:0] s, input logic [7:0] e, input string n);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : ck
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // Strobe stays up so writes can run back to back
  task wr(input apo_addr_t a, input apo_byte_t d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
  endtask : wr
  task idle;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
  endtask : idle
  task rd(input apo_addr_t a, input apo_byte_t e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    #1 ck(regHit, a inside {[8'h22:8'h29]}, "hit");
    idle;
    #1 ck(regRdata, e, "rdata");
  endtask : rd
  // Hang guard at 2000 cycles, far beyond the under a hundred cycles needed
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h22, 8'h00);
    ck(pathL, seq, "pathL");
    foreach (rows[i]) wr(rows[i][23:16], rows[i][15:8]);
    idle;
    foreach (rows[i]) rd(rows[i][23:16], rows[i][7:0]);
    // Full override ignores a sequencer change
    seq <= 8'h96;
    idle;
    #1 ck(pathL, ~8'hA5, "pathL");
    ck(auxL, ~8'h5A, "auxL");
    ck(pathR, ~8'h0A, "pathR");
    ck(auxR, ~8'hC3, "auxR");
    // Single override bits; the rest fall back to the sequencer
    wr(8'h22, 8'h20);
    wr(8'h26, 8'h10);
    wr(8'h23, 8'h10);
    idle;
    #1 ck(pathL, (8'h20 & ~8'hA5) | (8'hDF & seq), "pathL");
    ck(pathR, (8'h10 & ~8'h0A) | (8'hEF & seq), "pathR");
    ck(auxL, (8'h10 & ~8'h5A) | (8'hEF & seq), "auxL");
    // Read right behind a write, then a collision reads the old value while the write lands
    wr(8'h24, 8'h3C);
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b1;
    regWdata <= 8'h00;
    #1 ck(regRdata, 8'h3C, "rdata");
    idle;
    #1 ck(regRdata, 8'h3C, "rdata");
    rd(8'h24, 8'h00);
    // Reset in mid-run drops every override
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h29, 8'h00);
    ck(auxR, seq, "auxR");
    ck(pathL, seq, "pathL");
    ck(auxL, seq, "auxL");
    ck(pathR, seq, "pathR");
    give_verdict;
  end
endmodule : apo_analog_power_override_regs_tb
bind apo_analog_power_override_regs apo_regs_chk chk_u (.clk, .sys_rst, .regWrite, .regRead,
  .regAddr, .regWdata, .regRdata, .regHit, .seqPathPwrdnLeft, .pathPwrdnLeft, .auxPwrdnLeft,
  .pathPwrdnRight, .auxPwrdnRight);

// >>> verif/apo_regs_chk.sv
`timescale 1ns/10ps
// ----------------
// Port checks of the override bank
// ----------------
module apo_regs_chk
  import apo_pkg::*;
(
  // Clock and register port
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire apo_addr_t regAddr,
  input wire apo_byte_t regWdata,
  input wire apo_byte_t regRdata,
  input wire logic regHit,
  // Power side
  input wire logic [7:0] seqPathPwrdnLeft,
  input wire logic [7:0] pathPwrdnLeft,
  input wire logic [7:0] auxPwrdnLeft,
  input wire logic [7:0] pathPwrdnRight,
  input wire logic [7:0] auxPwrdnRight
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Decode, reset and read path
  hit_decode_a: assert property (
    (regWrite || regRead) |-> regHit == (regAddr inside {[8'h22:8'h29]}))
    else $error("decode wrong");
  reset_clear_a: assert property (
    $past(sys_rst) |-> regRdata == 8'h00 && pathPwrdnLeft == seqPathPwrdnLeft)
    else $error("not clear after reset");
  read_back_a: assert property (
    (regWrite && regHit) ##1 (regRead && !regWrite && regAddr == $past(regAddr))
    |=> regRdata == $past(regWdata, 2)) else $error("read after write differs");
  // Full override then state write: outputs are the inverted state
  bias_left_a: assert property (
    (regWrite && regAddr == 8'h22 && regWdata == 8'hFF) ##1 (regWrite && regAddr == 8'h24)
    |=> pathPwrdnLeft == ~$past(regWdata)) else $error("left path not forced");
  aux_left_a: assert property (
    (regWrite && regAddr == 8'h23 && regWdata == 8'hFF) ##1 (regWrite && regAddr == 8'h25)
    |=> auxPwrdnLeft == ~$past(regWdata)) else $error("left aux not forced");
  right_path_a: assert property (
    (regWrite && regAddr == 8'h26 && regWdata == 8'hFF) ##1 (regWrite && regAddr == 8'h28)
    |=> pathPwrdnRight == ~$past(regWdata)) else $error("right path not forced");
  right_aux_a: assert property (
    (regWrite && regAddr == 8'h27 && regWdata == 8'hFF) ##1 (regWrite && regAddr == 8'h29)
    |=> auxPwrdnRight == ~$past(regWdata)) else $error("right aux not forced");
  // Bits left at 0 keep following the sequencer
  normal_path_a: assert property (
    (regWrite && regAddr == 8'h22 && regWdata == 8'h20)
    |=> pathPwrdnLeft[4:0] == seqPathPwrdnLeft[4:0]) else $error("normal path lost");
endmodule : apo_regs_chk

// >>> verilog/apo_analog_power_override_regs.sv
`timescale 1ns/10ps
`include "apo_defs.svh"
// Summary of operation
// - Bit 5 of 0x22 overrides bias reference power control (1 = override).
// - Bit 4 of 0x22 overrides left current DAC power control.
// - Bits 3..0 of 0x22 override left driver, driver bias, CM feedback, output stage.
// - Bits 7,6,5 of 0x23 override left gain control, analog mute, dummy mute.
// - Bit 4 of 0x23 overrides negative charge pump power control.
// - Bits 3..0 of 0x23 override left offset cal, short prot, imp sense, whole imp sense.
// - Bit 5 of 0x24 is the forced state of the bias reference (1 = up).
// - Bits 4..0 of 0x24 are forced states of left DAC, driver, bias, CM feedback, out stage.
// - Bits 7,6,5 of 0x25 are forced states of left gain control, mute, dummy mute.
// - Bit 4 of 0x25 is the forced state of the negative charge pump.
// - Bits 3..0 of 0x25 are forced states of left offset cal, short, imp, whole imp.
// - Bits 4..0 of 0x26 override right DAC, driver, bias, CM feedback, out stage.
// - Register 0x28 holds the forced states of the right path stages.
// - Register 0x27 holds the right auxiliary overrides with the same encoding.
module apo_analog_power_override_regs
  import apo_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire apo_addr_t regAddr,
  input wire apo_byte_t regWdata,
  output apo_byte_t regRdata,
  output logic regHit,
  // Normal sequencer power-downs, 1 = powered down
  input wire logic [7:0] seqPathPwrdnLeft,
  input wire logic [7:0] seqAuxPwrdnLeft,
  input wire logic [7:0] seqPathPwrdnRight,
  input wire logic [7:0] seqAuxPwrdnRight,
  // Power-downs to analog blocks, 1 = powered down
  output logic [7:0] pathPwrdnLeft,
  output logic [7:0] auxPwrdnLeft,
  output logic [7:0] pathPwrdnRight,
  output logic [7:0] auxPwrdnRight
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  apo_byte_t biasLeftPathOvr;
  apo_byte_t leftAuxOvr;
  apo_byte_t biasLeftPathState;
  apo_byte_t leftAuxState;
  apo_byte_t rightPathOvr;
  apo_byte_t rightAuxOvr;
  apo_byte_t rightPathState;
  apo_byte_t rightAuxState;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic selBiasLeftOvr = (regAddr == `APO_ADDR_BIAS_LEFT_OVR);
  wire logic selLeftAuxOvr = (regAddr == `APO_ADDR_LEFT_AUX_OVR);
  wire logic selBiasLeftState = (regAddr == `APO_ADDR_BIAS_LEFT_STATE);
  wire logic selLeftAuxState = (regAddr == `APO_ADDR_LEFT_AUX_STATE);
  wire logic selRightPathOvr = (regAddr == `APO_ADDR_RIGHT_PATH_OVR);
  wire logic selRightAuxOvr = (regAddr == `APO_ADDR_RIGHT_AUX_OVR);
  wire logic selRightPathState = (regAddr == `APO_ADDR_RIGHT_PATH_STATE);
  wire logic selRightAuxState = (regAddr == `APO_ADDR_RIGHT_AUX_STATE);
  wire logic anySel = selBiasLeftOvr | selLeftAuxOvr | selBiasLeftState | selLeftAuxState |
                      selRightPathOvr | selRightAuxOvr | selRightPathState | selRightAuxState;

  // Hit is combinational so the port controller can ack in the same cycle
  assign regHit = anySel & (regRead | regWrite);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Whole byte stored, reserved bits included, so reads return what was written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      biasLeftPathOvr <= `APO_RESET_VALUE;
      leftAuxOvr <= `APO_RESET_VALUE;
      biasLeftPathState <= `APO_RESET_VALUE;
      leftAuxState <= `APO_RESET_VALUE;
      rightPathOvr <= `APO_RESET_VALUE;
      rightAuxOvr <= `APO_RESET_VALUE;
      rightPathState <= `APO_RESET_VALUE;
      rightAuxState <= `APO_RESET_VALUE;
    end else if (regWrite) begin
      if (selBiasLeftOvr) biasLeftPathOvr <= regWdata;
      if (selLeftAuxOvr) leftAuxOvr <= regWdata;
      if (selBiasLeftState) biasLeftPathState <= regWdata;
      if (selLeftAuxState) leftAuxState <= regWdata;
      if (selRightPathOvr) rightPathOvr <= regWdata;
      if (selRightAuxOvr) rightAuxOvr <= regWdata;
      if (selRightPathState) rightPathState <= regWdata;
      if (selRightAuxState) rightAuxState <= regWdata;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Registered read data; unmapped addresses read zero
  apo_byte_t next_regRdata;
  assign next_regRdata = selBiasLeftOvr ? biasLeftPathOvr :
                         selLeftAuxOvr ? leftAuxOvr :
                         selBiasLeftState ? biasLeftPathState :
                         selLeftAuxState ? leftAuxState :
                         selRightPathOvr ? rightPathOvr :
                         selRightAuxOvr ? rightAuxOvr :
                         selRightPathState ? rightPathState :
                         selRightAuxState ? rightAuxState : `APO_RESET_VALUE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= `APO_RESET_VALUE;
    end else if (regRead) begin
      regRdata <= next_regRdata;
    end
  end

  // ----------------------------------------
  // Power-down selection
  // ----------------------------------------
  // Reserved bits act as override bits too; analog side ignores their outputs
  apo_power_mux #(.WIDTH(8)) u_mux_left_path (
    .ovrEn(biasLeftPathOvr),
    .forcedUp(biasLeftPathState),
    .seqPwrdn(seqPathPwrdnLeft),
    .pwrdn(pathPwrdnLeft)
  );

  apo_power_mux #(.WIDTH(8)) u_mux_left_aux (
    .ovrEn(leftAuxOvr),
    .forcedUp(leftAuxState),
    .seqPwrdn(seqAuxPwrdnLeft),
    .pwrdn(auxPwrdnLeft)
  );

  apo_power_mux #(.WIDTH(8)) u_mux_right_path (
    .ovrEn(rightPathOvr),
    .forcedUp(rightPathState),
    .seqPwrdn(seqPathPwrdnRight),
    .pwrdn(pathPwrdnRight)
  );

  apo_power_mux #(.WIDTH(8)) u_mux_right_aux (
    .ovrEn(rightAuxOvr),
    .forcedUp(rightAuxState),
    .seqPwrdn(seqAuxPwrdnRight),
    .pwrdn(auxPwrdnRight)
  );

endmodule : apo_analog_power_override_regs

// >>> verilog/apo_defs.svh
`ifndef APO_DEFS_SVH
`define APO_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses on the control port)
// ----------------------------------------
`define APO_ADDR_BIAS_LEFT_OVR 8'h22
`define APO_ADDR_LEFT_AUX_OVR 8'h23
`define APO_ADDR_BIAS_LEFT_STATE 8'h24
`define APO_ADDR_LEFT_AUX_STATE 8'h25
`define APO_ADDR_RIGHT_PATH_OVR 8'h26
`define APO_ADDR_RIGHT_AUX_OVR 8'h27
`define APO_ADDR_RIGHT_PATH_STATE 8'h28
`define APO_ADDR_RIGHT_AUX_STATE 8'h29

// ----------------------------------------
// Reset value shared by every register
// ----------------------------------------
`define APO_RESET_VALUE 8'h00

// ----------------------------------------
// Field positions, path registers
// ----------------------------------------
`define APO_BIT_BIAS_REF 5
`define APO_BIT_DAC 4
`define APO_BIT_DRIVER 3
`define APO_BIT_DRIVER_BIAS 2
`define APO_BIT_CM_FEEDBACK 1
`define APO_BIT_OUT_STAGE 0

// ----------------------------------------
// Field positions, auxiliary registers
// ----------------------------------------
`define APO_BIT_GAIN_CTL 7
`define APO_BIT_MUTE 6
`define APO_BIT_DUMMY_MUTE 5
`define APO_BIT_NEG_PUMP 4
`define APO_BIT_OFFSET_CAL 3
`define APO_BIT_SHORT_PROT 2
`define APO_BIT_IMP_SENSE 1
`define APO_BIT_IMP_WHOLE 0

`endif

// >>> verilog/apo_pkg.sv
package apo_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [7:0] apo_byte_t;
  typedef logic [7:0] apo_addr_t;

endpackage : apo_pkg

// >>> verilog/apo_power_mux.sv
`timescale 1ns/10ps
// ----------------------------------------
// Per-group power-down selection
// ----------------------------------------
module apo_power_mux #(
  parameter int WIDTH = 8
) (
  // Software controls
  input wire logic [WIDTH-1:0] ovrEn,
  input wire logic [WIDTH-1:0] forcedUp,
  // Sequencer and analog side
  input wire logic [WIDTH-1:0] seqPwrdn,
  output logic [WIDTH-1:0] pwrdn
);

  // Forced state is "1 = up", so invert into power-down sense
  assign pwrdn = (ovrEn & ~forcedUp) | (~ovrEn & seqPwrdn);

endmodule : apo_power_mux
